// ===== rtl/trace_fmt_regs.svh
`ifndef TRACE_FMT_REGS_SVH
`define TRACE_FMT_REGS_SVH

// status codes
`define ST_TAKEN 5'h05
`define ST_MARK_2B 5'h0d
`define ST_MARK_3B 5'h0e
`define ST_EXC_FIRST 5'h1c
`define ST_OPD_BYTE 5'h08
`define ST_OPD_WORD 5'h09
`define ST_OPD_LONG 5'h0b

// entry layout
`define ENT_STATUS_BIT 1'h0
`define ENT_DATA_BIT 1'h1
`define ENT_ADDR_PFX 2'h2

// branch target bytes setting
`define BTB_OFF 2'h0
`define BTB_2B 2'h1
`define BTB_3B 2'h2

// nibble counts
`define NIB_ADDR_2B 4'h4
`define NIB_ADDR_3B 4'h6
`define NIB_OPD_BYTE 4'h2
`define NIB_OPD_WORD 4'h4
`define NIB_OPD_LONG 4'h8

// repeat limit for multi-cycle modes
`define REP_MAX 2'h2
`define REP_ONE 2'h1

`endif

// ===== rtl/trace_fmt_pkg.sv
package trace_fmt_pkg;

    typedef enum logic [2:0] {
        S_IDLE = 3'h1,
        S_MARK = 3'h2,
        S_SER = 3'h4
    } fmt_state_t;

    typedef logic [5:0] tb_entry_t;

endpackage

// ===== rtl/nibble_ser_if.sv
interface nibble_ser_if;
    logic start;
    logic [31:0] value;
    logic [3:0] count;
    logic [1:0] prefix;
    trace_fmt_pkg::tb_entry_t entry;
    logic valid;
    logic last;

    modport ctrl (output start, output value, output count, output prefix, input entry, input valid, input last);
    modport ser (input start, input value, input count, input prefix, output entry, output valid, output last);
endinterface

// ===== rtl/nibble_serializer.sv
`include "trace_fmt_regs.svh"

module nibble_serializer (
    input wire logic core_clk_i,
    input wire logic nrst_i,
    nibble_ser_if.ser s
);
    logic [31:0] val_q;
    logic [31:0] val_d;
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    logic [1:0] pfx_q;
    logic [1:0] pfx_d;

    // least significant nibble first
    always_comb begin
        val_d = val_q;
        cnt_d = cnt_q;
        pfx_d = pfx_q;
        if (s.start) begin
            val_d = s.value;
            cnt_d = s.count;
            pfx_d = s.prefix;
        end else if (cnt_q != 4'h0) begin
            val_d = val_q >> 4;
            cnt_d = cnt_q - 4'h1;
        end
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            val_q <= 32'h0;
            cnt_q <= 4'h0;
            pfx_q <= 2'h0;
        end else begin
            val_q <= val_d;
            cnt_q <= cnt_d;
            pfx_q <= pfx_d;
        end
    end

    assign s.entry = {pfx_q, val_q[3:0]};
    assign s.valid = cnt_q != 4'h0;
    assign s.last = cnt_q == 4'h1;
endmodule // nibble_serializer

// ===== rtl/trace_buffer_entry_formatter.sv
// Function
// - a taken branch writes status 0x05 into the trace buffer.
// - target captured only for taken branches flagged as variant addressing.
// - branch target bytes setting selects no capture, two or three bytes.
// - marker 0x0d or 0x0e written directly before address nibbles.
// - multi-byte values are emitted least significant nibble first.
// - every trace buffer entry is six bits wide.
// - status entry 0+code; data entry 1, read/write bit, nibble.
// - address entry is prefix 10 plus nibble of address shifted right one.
// - two-byte register jump gives 05, 0d, then four address nibbles.
// - interrupt gives two 1c, then 05, 0d and vector nibbles.
// - operand capture disabled means no operand data entries.
// - multi-cycle exception code recorded twice, further repeats suppressed.
// - successive entries go to consecutive buffer locations.
`include "trace_fmt_regs.svh"

module trace_buffer_entry_formatter #(
    parameter int DEPTH = 64,
    parameter int AW = $clog2(DEPTH)
) (
    input wire logic core_clk_i,
    input wire logic nrst_i,
    input wire logic pst_valid_i,
    input wire logic [4:0] pst_code_i,
    input wire logic variant_i,
    input wire logic [31:0] target_i,
    input wire logic opd_valid_i,
    input wire logic opd_rw_i,
    input wire logic [31:0] opd_data_i,
    input wire logic [1:0] branch_target_bytes_i,
    input wire logic opd_capture_en_i,
    output logic pst_ready_o,
    output logic tb_we_o,
    output logic [AW-1:0] tb_addr_o,
    output logic [5:0] tb_entry_o
);
    localparam logic [AW-1:0] LAST_LOC = AW'(DEPTH - 1);

    trace_fmt_pkg::fmt_state_t state_q;
    trace_fmt_pkg::fmt_state_t state_d;
    logic ready_q;
    logic ready_d;
    logic we_q;
    logic we_d;
    logic [AW-1:0] addr_q;
    logic [AW-1:0] addr_d;
    logic [AW-1:0] wptr_q;
    logic [AW-1:0] wptr_d;
    trace_fmt_pkg::tb_entry_t entry_q;
    trace_fmt_pkg::tb_entry_t entry_d;
    logic [4:0] last_code_q;
    logic [4:0] last_code_d;
    logic [1:0] rep_q;
    logic [1:0] rep_d;
    logic [23:0] tgt_q;
    logic [23:0] tgt_d;
    logic three_q;
    logic three_d;
    logic take;
    logic capture;
    logic is_opd;
    logic is_multi;
    logic suppress;
    logic [3:0] opd_nibs;

    nibble_ser_if ser_bus();

    nibble_serializer u_ser (
        .core_clk_i(core_clk_i),
        .nrst_i(nrst_i),
        .s(ser_bus)
    );

    always_comb begin
        take = pst_valid_i && ready_q;
        capture = (pst_code_i == `ST_TAKEN) && variant_i && (branch_target_bytes_i != `BTB_OFF);
        is_opd = (pst_code_i == `ST_OPD_BYTE) || (pst_code_i == `ST_OPD_WORD) || (pst_code_i == `ST_OPD_LONG);
        is_multi = pst_code_i >= `ST_EXC_FIRST;
        suppress = is_multi && (pst_code_i == last_code_q) && (rep_q == `REP_MAX);
        unique case (pst_code_i)
            `ST_OPD_BYTE: opd_nibs = `NIB_OPD_BYTE;
            `ST_OPD_WORD: opd_nibs = `NIB_OPD_WORD;
            default: opd_nibs = `NIB_OPD_LONG;
        endcase
    end

    always_comb begin
        state_d = state_q;
        we_d = 1'b0;
        entry_d = entry_q;
        last_code_d = last_code_q;
        rep_d = rep_q;
        tgt_d = tgt_q;
        three_d = three_q;
        ser_bus.start = 1'b0;
        ser_bus.value = 32'h0;
        ser_bus.count = 4'h0;
        ser_bus.prefix = 2'h0;
        unique case (state_q)
            trace_fmt_pkg::S_IDLE: begin
                if (take) begin
                    we_d = !suppress;
                    entry_d = {`ENT_STATUS_BIT, pst_code_i};
                    if (pst_code_i == last_code_q) begin
                        rep_d = (rep_q == `REP_MAX) ? rep_q : rep_q + `REP_ONE;
                    end else begin
                        rep_d = `REP_ONE;
                        last_code_d = pst_code_i;
                    end
                    if (capture) begin
                        state_d = trace_fmt_pkg::S_MARK;
                        tgt_d = target_i[24:1];
                        three_d = branch_target_bytes_i == `BTB_3B;
                    end else if (is_opd && opd_valid_i && opd_capture_en_i) begin
                        ser_bus.start = 1'b1;
                        ser_bus.value = opd_data_i;
                        ser_bus.count = opd_nibs;
                        ser_bus.prefix = {`ENT_DATA_BIT, opd_rw_i};
                        state_d = trace_fmt_pkg::S_SER;
                    end
                end
            end
            trace_fmt_pkg::S_MARK: begin
                // marker right after the 0x05 entry, nibbles follow at once
                we_d = 1'b1;
                entry_d = {`ENT_STATUS_BIT, three_q ? `ST_MARK_3B : `ST_MARK_2B};
                ser_bus.start = 1'b1;
                ser_bus.value = {8'h0, tgt_q};
                ser_bus.count = three_q ? `NIB_ADDR_3B : `NIB_ADDR_2B;
                ser_bus.prefix = `ENT_ADDR_PFX;
                state_d = trace_fmt_pkg::S_SER;
            end
            trace_fmt_pkg::S_SER: begin
                we_d = ser_bus.valid;
                entry_d = ser_bus.entry;
                if (ser_bus.last) begin
                    state_d = trace_fmt_pkg::S_IDLE;
                end
            end
        endcase
        ready_d = state_d == trace_fmt_pkg::S_IDLE;
        addr_d = we_d ? wptr_q : addr_q;
        wptr_d = wptr_q;
        if (we_d) begin
            wptr_d = (wptr_q == LAST_LOC) ? '0 : wptr_q + 1'b1;
        end
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_q <= trace_fmt_pkg::S_IDLE;
            ready_q <= 1'b0;
            we_q <= 1'b0;
            addr_q <= '0;
            wptr_q <= '0;
            entry_q <= 6'h0;
            last_code_q <= 5'h0;
            rep_q <= 2'h0;
            tgt_q <= 24'h0;
            three_q <= 1'b0;
        end else begin
            state_q <= state_d;
            ready_q <= ready_d;
            we_q <= we_d;
            addr_q <= addr_d;
            wptr_q <= wptr_d;
            entry_q <= entry_d;
            last_code_q <= last_code_d;
            rep_q <= rep_d;
            tgt_q <= tgt_d;
            three_q <= three_d;
        end
    end

    assign pst_ready_o = ready_q;
    assign tb_we_o = we_q;
    assign tb_addr_o = addr_q;
    assign tb_entry_o = entry_q;

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!nrst_i);

    chk_taken_status: assert property (
        (pst_valid_i && pst_ready_o && pst_code_i == `ST_TAKEN)
            |=> tb_we_o && tb_entry_o == {`ENT_STATUS_BIT, `ST_TAKEN})
        else $error("taken branch status entry missing");

    chk_marker_2b: assert property (
        (pst_valid_i && pst_ready_o && pst_code_i == `ST_TAKEN && variant_i && branch_target_bytes_i == `BTB_2B)
            |=> ##1 tb_we_o && tb_entry_o == {`ENT_STATUS_BIT, `ST_MARK_2B})
        else $error("two-byte marker not after taken branch");

    chk_jump_nibbles: assert property (
        (pst_valid_i && pst_ready_o && pst_code_i == `ST_TAKEN && variant_i && branch_target_bytes_i == `BTB_2B)
            |=> ##2 (tb_we_o && tb_entry_o[5:4] == `ENT_ADDR_PFX && !pst_ready_o)[*3]
            ##1 (tb_we_o && tb_entry_o[5:4] == `ENT_ADDR_PFX && pst_ready_o))
        else $error("two-byte address nibble run wrong");

    chk_first_nibble: assert property (
        (pst_valid_i && pst_ready_o && pst_code_i == `ST_TAKEN && variant_i && branch_target_bytes_i != `BTB_OFF)
            |=> ##2 tb_entry_o[3:0] == $past(target_i[4:1], 3))
        else $error("first address nibble is not address bits 4:1");

    chk_no_capture_off: assert property (
        (pst_valid_i && pst_ready_o && branch_target_bytes_i == `BTB_OFF && !is_opd) |=> pst_ready_o)
        else $error("address captured while capture is off");

    chk_no_opd_data: assert property (
        (pst_valid_i && pst_ready_o && !opd_capture_en_i && !capture) |=> pst_ready_o ##1 (!tb_entry_o[5] || !tb_we_o))
        else $error("operand data entry while capture disabled");

    chk_opd_first_nibble: assert property (
        (pst_valid_i && pst_ready_o && is_opd && opd_valid_i && opd_capture_en_i)
            |=> ##1 tb_we_o && tb_entry_o == {`ENT_DATA_BIT, $past(opd_rw_i, 2), $past(opd_data_i[3:0], 2)})
        else $error("operand data not least nibble first");

    chk_exc_twice: assert property (
        (pst_valid_i && pst_ready_o && pst_code_i == `ST_EXC_FIRST)[*3] |=> !tb_we_o)
        else $error("third exception status not suppressed");

    chk_ptr_step: assert property (
        (tb_we_o ##1 tb_we_o) |-> tb_addr_o == (($past(tb_addr_o) == LAST_LOC) ? '0 : $past(tb_addr_o) + 1'b1))
        else $error("write location not consecutive");
endmodule // trace_buffer_entry_formatter

// ===== verif/core_status_model.sv
module core_status_model (
    input wire logic core_clk_i,
    input wire logic nrst_i,
    input wire logic pst_ready_i,
    output logic pst_valid_o,
    output logic [4:0] pst_code_o,
    output logic variant_o,
    output logic [31:0] target_o,
    output logic opd_valid_o,
    output logic opd_rw_o,
    output logic [31:0] opd_data_o
);
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [4:0] code;
        logic variant;
        logic [31:0] target;
        logic opd_valid;
        logic rw;
        logic [31:0] data;
    } core_req_t;
    core_req_t q[$];
    core_req_t cur;
    logic taken_q = 1'b0;
    initial begin
        {pst_valid_o, pst_code_o, variant_o, target_o, opd_valid_o, opd_rw_o, opd_data_o} = '0;
    end
    always @(posedge core_clk_i) taken_q <= pst_valid_o && pst_ready_i;
    // a request is held until taken; released lines are scrambled so stale values never look valid
    always @(negedge core_clk_i) begin
        if (taken_q || !pst_valid_o) begin
            if (nrst_i && q.size() > 0) begin
                cur = q.pop_front();
                {pst_code_o, variant_o, target_o, opd_valid_o, opd_rw_o, opd_data_o} = cur;
                pst_valid_o = 1'b1;
            end else begin
                pst_valid_o = 1'b0;
                {pst_code_o, variant_o, target_o, opd_valid_o, opd_rw_o, opd_data_o} =
                    ~{pst_code_o, variant_o, target_o, opd_valid_o, opd_rw_o, opd_data_o};
            end
        end
    end
    task push(input core_req_t r);
        q.push_back(r);
    endtask
    function int pending();
        return q.size();
    endfunction
endmodule // core_status_model

// ===== verif/trace_buffer_entry_formatter_bench.sv
module trace_buffer_entry_formatter_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic pst_valid_i, variant_i, opd_valid_i, opd_rw_i, pst_ready_o, tb_we_o;
    logic [4:0] pst_code_i;
    logic [31:0] target_i, opd_data_i;
    logic [1:0] branch_target_bytes_i = 2'h0;
    logic opd_capture_en_i = 1'b0;
    logic [2:0] tb_addr_o;
    logic [5:0] tb_entry_o;
    logic [5:0] exp_q[$];
    logic [5:0] got_q[$];
    logic [2:0] wptr = 3'h0;
    int n_mismatch = 0;
    int n_tests = 0;
    always #5 core_clk_i = ~core_clk_i;
    core_status_model u_core_status_model (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .pst_ready_i(pst_ready_o),
        .pst_valid_o(pst_valid_i), .pst_code_o(pst_code_i), .variant_o(variant_i), .target_o(target_i),
        .opd_valid_o(opd_valid_i), .opd_rw_o(opd_rw_i), .opd_data_o(opd_data_i));
    // small depth so the pointer wraps several times
    trace_buffer_entry_formatter #(.DEPTH(8)) u_trace_buffer_entry_formatter (.core_clk_i(core_clk_i),
        .nrst_i(nrst_i), .pst_valid_i(pst_valid_i), .pst_code_i(pst_code_i), .variant_i(variant_i),
        .target_i(target_i), .opd_valid_i(opd_valid_i), .opd_rw_i(opd_rw_i), .opd_data_i(opd_data_i),
        .branch_target_bytes_i(branch_target_bytes_i), .opd_capture_en_i(opd_capture_en_i),
        .pst_ready_o(pst_ready_o), .tb_we_o(tb_we_o), .tb_addr_o(tb_addr_o), .tb_entry_o(tb_entry_o));
    task cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    always @(negedge core_clk_i) begin
        if (!nrst_i) wptr <= 3'h0;
        else if (tb_we_o === 1'b1) begin
            cmp("tb_addr_o", {29'h0, wptr}, {29'h0, tb_addr_o});
            got_q.push_back(tb_entry_o);
            wptr <= wptr + 3'h1;
        end
    end
    task req(input logic [4:0] c, input logic v, input logic [31:0] t, input logic ov, input logic [31:0] d);
        u_core_status_model.push({c, v, t, ov, d[31], d});
    endtask
    task e_st(input logic [4:0] c);
        exp_q.push_back({1'b0, c});
    endtask
    task e_adr(input logic [4:0] mark, input logic [31:0] t, input int n);
        logic [31:0] a;
        a = t >> 1;
        e_st(5'h05);
        e_st(mark);
        for (int i = 0; i < n; i++) exp_q.push_back({2'h2, a[4*i+:4]});
    endtask
    task check(input string name);
        int k;
        k = 0;
        while ((u_core_status_model.pending() != 0 || pst_valid_i !== 1'b0 || pst_ready_o !== 1'b1) && k < 200) begin
            @(negedge core_clk_i);
            k++;
        end
        if (k == 200) cmp({name, " idle"}, 32'h1, 32'h0);
        repeat (3) @(negedge core_clk_i);
        cmp({name, " count"}, 32'(exp_q.size()), 32'(got_q.size()));
        for (int i = 0; i < exp_q.size() && i < got_q.size(); i++) cmp(name, {26'h0, exp_q[i]}, {26'h0, got_q[i]});
        exp_q.delete();
        got_q.delete();
        $display("test %s done", name);
    endtask
    task t_plain();
        branch_target_bytes_i = 2'h1;
        req(5'h01, 0, 32'h0, 0, 32'h0); e_st(5'h01);
        req(5'h12, 0, 32'h0, 0, 32'h0); e_st(5'h12);
        req(5'h05, 0, 32'h1074, 0, 32'h0); e_st(5'h05);
        req(5'h1a, 0, 32'h0, 0, 32'h0); e_st(5'h1a);
        check("plain");
    endtask
    task t_jump2();
        req(5'h05, 1, 32'h00001074, 0, 32'h0); e_adr(5'h0d, 32'h00001074, 4);
        req(5'h05, 1, 32'h0000a864, 0, 32'h0); e_adr(5'h0d, 32'h0000a864, 4);
        check("jump2");
    endtask
    task t_btb();
        for (int b = 0; b < 4; b++) begin
            branch_target_bytes_i = 2'(b);
            req(5'h05, 1, 32'h00abcdef, 0, 32'h0);
            if (b == 0) e_st(5'h05);
            else if (b == 2) e_adr(5'h0e, 32'h00abcdef, 6);
            else e_adr(5'h0d, 32'h00abcdef, 4);
            check("btb");
        end
    endtask
    task t_exc();
        branch_target_bytes_i = 2'h1;
        req(5'h01, 0, 32'h0, 0, 32'h0); e_st(5'h01);
        repeat (4) req(5'h1c, 0, 32'h0, 0, 32'h0);
        e_st(5'h1c); e_st(5'h1c);
        req(5'h05, 1, 32'h00001074, 0, 32'h0); e_adr(5'h0d, 32'h00001074, 4);
        repeat (3) req(5'h1f, 0, 32'h0, 0, 32'h0);
        e_st(5'h1f); e_st(5'h1f);
        check("exception");
    endtask
    task t_data();
        logic [4:0] codes[3];
        int nibs[3];
        logic [31:0] d;
        codes = '{5'h08, 5'h09, 5'h0b};
        nibs = '{2, 4, 8};
        for (int en = 1; en >= 0; en--) begin
            opd_capture_en_i = en[0];
            for (int i = 0; i < 3; i++) begin
                // each operand differs, so the expected nibbles follow the value actually sent
                d = 32'h87654321 ^ 32'(i);
                req(codes[i], 0, 32'h0, 1, d);
                e_st(codes[i]);
                for (int j = 0; j < nibs[i] * en; j++) exp_q.push_back({2'h3, d[4*j+:4]});
            end
            req(5'h0b, 0, 32'h0, 0, 32'h12345678); e_st(5'h0b);
            check("data");
        end
    endtask
    task finish_test();
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        #200000;
        n_mismatch++;
        $display("mismatch watchdog expected done seen timeout");
        finish_test();
    end
    initial begin
        repeat (12) @(negedge core_clk_i);
        nrst_i = 1'b1;
        repeat (2) @(negedge core_clk_i);
        t_plain();
        t_jump2();
        t_btb();
        t_exc();
        t_data();
        finish_test();
    end
endmodule // trace_buffer_entry_formatter_bench
